// file: verif/bus_dev_model.sv
`timescale 1ns/100ps
module bus_dev_model #(
  parameter int HOLD = 30
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_want,
  input  wire logic [2:0] i_pri,
  input  wire logic       i_grant,
  output logic            o_req,
  output logic      [2:0] o_req_pri
);
  logic [7:0] held_r;

  assign o_req_pri = i_pri;

  // Keeps the bus for HOLD clocks once granted, then lets go
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !i_want) begin
      held_r <= 8'h00;
      o_req  <= 1'b0;
    end else begin
      if (i_grant) held_r <= held_r + 8'h01;
      o_req <= (held_r < 8'(HOLD));
    end
  end
endmodule

// file: verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic          clk, rst_n, psel, pen, pwr, irl, want, programmed_interrupt_request, hold, stk, odd, wx;
  logic          pready, pslverr, breq, we, cyc, trap, mst, eg, pg, er;
  logic [1:0]    cond;
  logic [7:0]    paddr, ca, vec, flg;
  logic [31:0]   pwd, prd, rd;
  logic [15:0]   ir;
  logic [2:0]    rpri, qpri, ppri, cpri, rsel;
  logic [5:0]    alu;
  logic [3:0]    cc;
  logic          rsv;
  mseq_pkg::dp_t dp;
  int            n_mismatch = 0;
  int            total_checks = 0;
  int            n;

  microprogram_sequencer #(.CYC_DIV(2)) dut_u (
    .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_IR_LOAD(irl), .I_IR_BUS(ir), .I_COND(cond), .I_CC(cc), .I_CONSOLE(1'b0),
    .I_SWITCH(3'h0), .I_PWR_FAIL(1'b0), .I_ODD_ADDR(odd), .I_WORD_XFER(wx),
    .I_STACK_OVF(stk), .I_RSVD_INSTR(rsv), .I_BUS_REQ(breq), .I_REQ_PRI(rpri),
    .I_PROGRAMMED_INTERRUPT_REQUEST_REQ(programmed_interrupt_request), .I_PROGRAMMED_INTERRUPT_REQUEST_PRI(ppri), .I_CPU_PRI(cpri), .I_CLK_HOLD(hold),
    .O_DP_CTRL(dp), .O_CTRL_ADDR(ca), .O_ALU_SEL(alu), .O_FLAG_CTL(flg), .O_REG_SEL(rsel),
    .O_REG_WE(we), .O_CYCLE(cyc), .O_TRAP_ACTIVE(trap), .O_TRAP_VEC(vec),
    .O_CPU_MASTER(mst), .O_EXT_GRANT(eg), .O_PROGRAMMED_INTERRUPT_REQUEST_GRANT(pg)
  );

  bus_dev_model #(.HOLD(30)) dev_u (
    .i_clk(clk), .i_rst_n(rst_n), .i_want(want), .i_pri(qpri), .i_grant(eg),
    .o_req(breq), .o_req_pri(rpri)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1; pwr <= w; paddr <= a; pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin n_mismatch++; conclude(); end
    rd = prd;
    er = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask

  task automatic ld(input logic [7:0] a, input logic [31:0] w);
    apb(1'b1, mseq_pkg::OFF_CS_ADDR, {24'h0, a});
    apb(1'b1, mseq_pkg::OFF_CS_DATA, w);
  endtask

  function automatic logic [31:0] mk(input logic [3:0] m, input mseq_pkg::rw_t rw,
      input mseq_pkg::flag_t fl, input logic [2:0] fk, input mseq_pkg::br_t br,
      input logic [7:0] nx, input logic u);
    mseq_pkg::cw_t w;
    w = '0;
    w.dp.dp_misc = m; w.dp.register_write_field = rw; w.dp.flag_update_field = fl;
    w.dp.reg_src = mseq_pkg::RS_FIELD; w.dp.reg_field = mseq_pkg::REG_PC;
    w.dp.ubus_xfer = u; w.fork_enable_field = fk; w.branch_enable_field = br;
    w.next_addr = nx;
    return w;
  endfunction

  task automatic step(input logic [7:0] x);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (cyc !== 1'b1 && k < 50);
    if (k >= 50) begin n_mismatch++; conclude(); end
    chk("ctrl_addr", {24'h0, ca}, {24'h0, x});
  endtask

  task automatic quiet(input int c);
    int k;
    k = 0;
    repeat (c) begin
      @(posedge clk);
      if (cyc !== 1'b0) k++;
    end
    chk("no_cycle", k, 0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude();
  end

  initial begin
    {rst_n, psel, pen, pwr, irl, want, programmed_interrupt_request, hold, stk, odd, wx} = '0;
    cond = 2'h1; paddr = 8'h00; pwd = '0; ir = 16'h0000;
    cc = 4'h4; rsv = 1'b0;
    qpri = 3'h5; ppri = 3'h6; cpri = 3'h3;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("rst_addr", {24'h0, ca}, {24'h0, mseq_pkg::START_ADDR});
    chk("rst_latch", dp, 32'h0);
    chk("rst_master", mst, 1);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_err", er, 1);
    chk("unmapped_data", rd, 0);
    apb(1'b1, mseq_pkg::OFF_STATUS, 32'hFFFF_FFFF);
    chk("status_wr_err", er, 0);
    ld(8'h00, mk(4'h5, mseq_pkg::RW_NONE, mseq_pkg::FL_HOLD, 3'h0, mseq_pkg::BR_NONE, 8'h01, 1'b0));
    ld(8'h01, mk(4'h0, mseq_pkg::RW_NONE, mseq_pkg::FL_HOLD, 3'h0, mseq_pkg::BR_DP0, 8'h02, 1'b0));
    ld(8'h03, mk(4'h0, mseq_pkg::RW_NONE, mseq_pkg::FL_HOLD, 3'h1, mseq_pkg::BR_NONE, 8'h20, 1'b0));
    ld(8'h2A, mk(4'h0, mseq_pkg::RW_COND, mseq_pkg::FL_CLEAR, 3'h3, mseq_pkg::BR_NONE, 8'h40, 1'b0));
    ld(8'h40, mk(4'h0, mseq_pkg::RW_WRITE, mseq_pkg::FL_LOAD, 3'h0, mseq_pkg::BR_TRAP, 8'h50, 1'b0));
    ld(8'h51, mk(4'h0, mseq_pkg::RW_NONE, mseq_pkg::FL_HOLD, 3'h0, mseq_pkg::BR_NONE, 8'h51, 1'b1));
    apb(1'b0, mseq_pkg::OFF_CS_ADDR, 32'h0);
    chk("cs_addr_inc", rd, 32'h52);
    apb(1'b0, mseq_pkg::OFF_STATUS, 32'h0);
    chk("status_master", rd[16], 1);
    irl <= 1'b1; ir <= 16'hA000;
    stk <= 1'b1; odd <= 1'b1; wx <= 1'b1; rsv <= 1'b1;
    @(posedge clk);
    {irl, stk, odd, wx, rsv} <= '0;
    repeat (2) @(posedge clk);
    chk("trap_on", trap, 1);
    chk("trap_vec", {24'h0, vec}, {24'h0, mseq_pkg::VEC_ODD});
    apb(1'b1, mseq_pkg::OFF_CTRL, 32'h1);
    step(8'h01);
    chk("latch_misc", {28'h0, dp.dp_misc}, 32'h5);
    chk("alu_sel", {26'h0, alu}, 32'h09);
    step(8'h03);
    step(8'h2A);
    step(8'h40);
    chk("cond_we_pc", we, 0);
    chk("reg_sel", rsel, 7);
    chk("flag_clear", flg, 32'hAA);
    step(8'h51);
    chk("write_we", we, 1);
    chk("flag_load", flg, 32'h55);
    @(posedge clk);
    chk("trap_off", trap, 0);
    step(8'h51);
    want <= 1'b1;
    n = 0;
    while (eg !== 1'b1 && n < 20) begin @(posedge clk); n++; end
    chk("ext_grant", eg, 1);
    chk("lost_master", mst, 0);
    quiet(8);
    n = 0;
    while (mst !== 1'b1 && n < 100) begin @(posedge clk); n++; end
    chk("master_back", mst, 1);
    step(8'h51);
    want <= 1'b0;
    @(posedge clk);
    qpri <= 3'h2; want <= 1'b1; programmed_interrupt_request <= 1'b1;
    n = 0;
    while (pg !== 1'b1 && n < 20) begin @(posedge clk); n++; end
    chk("programmed_interrupt_request_grant", pg, 1);
    chk("low_req", eg, 0);
    programmed_interrupt_request <= 1'b0; want <= 1'b0;
    n = 0;
    while (mst !== 1'b1 && n < 20) begin @(posedge clk); n++; end
    hold <= 1'b1;
    repeat (5) @(posedge clk);
    quiet(12);
    hold <= 1'b0;
    step(8'h51);
    conclude();
  end
endmodule

// file: verilog/microprogram_sequencer.sv
`timescale 1ns/100ps
module microprogram_sequencer #(
  parameter int CYC_DIV = mseq_pkg::CYC_DIV_DEF
) (
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  input  wire logic        I_IR_LOAD,
  input  wire logic [15:0] I_IR_BUS,
  input  wire logic [1:0]  I_COND,
  input  wire logic [3:0]  I_CC,
  input  wire logic        I_CONSOLE,
  input  wire logic [2:0]  I_SWITCH,
  input  wire logic        I_PWR_FAIL,
  input  wire logic        I_ODD_ADDR,
  input  wire logic        I_WORD_XFER,
  input  wire logic        I_STACK_OVF,
  input  wire logic        I_RSVD_INSTR,
  input  wire logic        I_BUS_REQ,
  input  wire logic [2:0]  I_REQ_PRI,
  input  wire logic        I_PROGRAMMED_INTERRUPT_REQUEST_REQ,
  input  wire logic [2:0]  I_PROGRAMMED_INTERRUPT_REQUEST_PRI,
  input  wire logic [2:0]  I_CPU_PRI,
  input  wire logic        I_CLK_HOLD,
  output mseq_pkg::dp_t    O_DP_CTRL,
  output logic      [7:0]  O_CTRL_ADDR,
  output logic      [5:0]  O_ALU_SEL,
  output logic      [7:0]  O_FLAG_CTL,
  output logic      [2:0]  O_REG_SEL,
  output logic             O_REG_WE,
  output logic             O_CYCLE,
  output logic             O_TRAP_ACTIVE,
  output logic      [7:0]  O_TRAP_VEC,
  output logic             O_CPU_MASTER,
  output logic             O_EXT_GRANT,
  output logic             O_PROGRAMMED_INTERRUPT_REQUEST_GRANT
);

  if (CYC_DIV < 2 || CYC_DIV > 255) begin : g_chk
    $error("CYC_DIV out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [5:0] alu_expand(input logic [2:0] f);
    case (f)
      3'h0:    alu_expand = 6'h09;
      3'h1:    alu_expand = 6'h26;
      3'h2:    alu_expand = 6'h10;
      3'h3:    alu_expand = 6'h3F;
      3'h4:    alu_expand = 6'h3B;
      3'h5:    alu_expand = 6'h3E;
      3'h6:    alu_expand = 6'h36;
      default: alu_expand = 6'h30;
    endcase
  endfunction

  function automatic logic [4:0] class_idx(input logic [15:0] ir);
    class_idx = ir[15:11];
  endfunction

  function automatic mseq_pkg::sub_t sub_rom(input logic [4:0] idx);
    case (idx)
      5'h01:   sub_rom = '{cls: 2'h1, flags: 8'h55, alu: 6'h09};
      5'h02:   sub_rom = '{cls: 2'h1, flags: 8'h55, alu: 6'h26};
      5'h03:   sub_rom = '{cls: 2'h2, flags: 8'h54, alu: 6'h3B};
      5'h04:   sub_rom = '{cls: 2'h2, flags: 8'h54, alu: 6'h3E};
      5'h05:   sub_rom = '{cls: 2'h3, flags: 8'h80, alu: 6'h10};
      5'h11:   sub_rom = '{cls: 2'h1, flags: 8'h57, alu: 6'h36};
      default: sub_rom = '{cls: 2'h0, flags: 8'h00, alu: 6'h30};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [2:0] as_1_r;
  logic [2:0] as_2_r;
  logic [2:0] as_3_r;
  logic [2:0] as_r;
  logic       pwr_s;
  logic       breq_s;
  logic       hold_s;

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      as_1_r <= 3'h0;
      as_2_r <= 3'h0;
      as_3_r <= 3'h0;
      as_r   <= 3'h0;
    end else begin
      as_1_r <= {I_PWR_FAIL, I_BUS_REQ, I_CLK_HOLD};
      as_2_r <= as_1_r;
      as_3_r <= as_2_r;
      as_r   <= (as_2_r & as_3_r) | (as_r & (as_2_r | as_3_r));
    end
  end

  assign {pwr_s, breq_s, hold_s} = as_r;

  ////////////////////////////////////////////////////////////////////////
  // APB slave and control store

  mseq_pkg::cw_t cs_mem [mseq_pkg::CS_WORDS];
  logic        run_r;
  logic [7:0]  cs_addr_r;
  logic        apb_wr;
  logic        stall;
  logic [31:0] rd_val;
  logic        rd_err;

  assign apb_wr = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;

  always_comb begin
    rd_val = 32'h0;
    rd_err = 1'b0;
    if (I_PADDR == mseq_pkg::OFF_CTRL) begin
      rd_val[mseq_pkg::CTRL_RUN] = run_r;
    end else if (I_PADDR == mseq_pkg::OFF_STATUS) begin
      rd_val[7:0] = O_CTRL_ADDR;
      rd_val[mseq_pkg::ST_VEC_LSB +: 8] = O_TRAP_VEC;
      rd_val[mseq_pkg::ST_MASTER] = O_CPU_MASTER;
      rd_val[mseq_pkg::ST_TRAP] = O_TRAP_ACTIVE;
      rd_val[mseq_pkg::ST_STALL] = stall;
    end else if (I_PADDR == mseq_pkg::OFF_CS_ADDR) begin
      rd_val[7:0] = cs_addr_r;
    end else if (I_PADDR == mseq_pkg::OFF_CS_DATA) begin
      rd_val = cs_mem[cs_addr_r];
    end else begin
      rd_err = 1'b1;
    end
  end

  // One wait state: data sampled in first access cycle
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      O_PREADY  <= 1'b0;
      O_PRDATA  <= 32'h0;
      O_PSLVERR <= 1'b0;
    end else if (I_PSEL && I_PENABLE && !O_PREADY) begin
      O_PREADY  <= 1'b1;
      O_PRDATA  <= I_PWRITE ? 32'h0 : rd_val;
      O_PSLVERR <= rd_err;
    end else begin
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      run_r     <= 1'b0;
      cs_addr_r <= 8'h00;
    end else if (apb_wr) begin
      if (I_PADDR == mseq_pkg::OFF_CTRL) begin
        run_r <= I_PWDATA[mseq_pkg::CTRL_RUN];
      end else if (I_PADDR == mseq_pkg::OFF_CS_ADDR) begin
        cs_addr_r <= I_PWDATA[7:0];
      end else if (I_PADDR == mseq_pkg::OFF_CS_DATA) begin
        cs_addr_r <= cs_addr_r + 8'h01;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (apb_wr && I_PADDR == mseq_pkg::OFF_CS_DATA) begin
      cs_mem[cs_addr_r] <= mseq_pkg::cw_t'(I_PWDATA);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Instruction registers

  logic [15:0] ir_r;
  logic [15:0] fetch_fork_instruction_copy;

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      ir_r                        <= 16'h0;
      fetch_fork_instruction_copy <= 16'h0;
    end else if (I_IR_LOAD) begin
      ir_r                        <= I_IR_BUS;
      fetch_fork_instruction_copy <= I_IR_BUS;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Trap detection and bus arbitration

  logic       trap_set;
  logic       trap_take;
  logic [7:0] vec_nxt;
  logic       ext_ok;
  logic       programmed_interrupt_request_ok;

  assign trap_set = pwr_s | (I_ODD_ADDR & I_WORD_XFER) | I_STACK_OVF | I_RSVD_INSTR;

  always_comb begin
    if (pwr_s) begin
      vec_nxt = mseq_pkg::VEC_PWR;
    end else if (I_ODD_ADDR && I_WORD_XFER) begin
      vec_nxt = mseq_pkg::VEC_ODD;
    end else if (I_STACK_OVF) begin
      vec_nxt = mseq_pkg::VEC_STACK;
    end else begin
      vec_nxt = mseq_pkg::VEC_RSVD;
    end
  end

  // New event wins over the clear by trap entry
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      O_TRAP_ACTIVE <= 1'b0;
      O_TRAP_VEC    <= 8'h00;
    end else if (trap_set) begin
      O_TRAP_ACTIVE <= 1'b1;
      if (!O_TRAP_ACTIVE || trap_take) begin
        O_TRAP_VEC <= vec_nxt;
      end
    end else if (trap_take) begin
      O_TRAP_ACTIVE <= 1'b0;
    end
  end

  assign ext_ok  = breq_s && (I_REQ_PRI > I_CPU_PRI);
  assign programmed_interrupt_request_ok = I_PROGRAMMED_INTERRUPT_REQUEST_REQ && (I_PROGRAMMED_INTERRUPT_REQUEST_PRI > I_CPU_PRI) && !ext_ok;

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      O_CPU_MASTER <= 1'b1;
      O_EXT_GRANT  <= 1'b0;
      O_PROGRAMMED_INTERRUPT_REQUEST_GRANT <= 1'b0;
    end else begin
      O_CPU_MASTER <= !(ext_ok || programmed_interrupt_request_ok);
      O_EXT_GRANT  <= ext_ok;
      O_PROGRAMMED_INTERRUPT_REQUEST_GRANT <= programmed_interrupt_request_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timing generator

  mseq_pkg::cw_t rom;
  logic [7:0]    div_r;
  logic          cyc_en;
  logic [7:0]    car_r [mseq_pkg::CAR_COPIES];

  assign rom = cs_mem[car_r[0]];

  // System-bus transfer waits for mastership, fast bus does not
  assign stall = hold_s | !run_r | (rom.dp.ubus_xfer & !O_CPU_MASTER);
  assign cyc_en = (div_r == 8'(CYC_DIV - 1)) && !stall;

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      div_r <= 8'h00;
    end else if (cyc_en) begin
      div_r <= 8'h00;
    end else if (div_r != 8'(CYC_DIV - 1)) begin
      div_r <= div_r + 8'h01;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      O_CYCLE <= 1'b0;
    end else begin
      O_CYCLE <= cyc_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next address

  logic [1:0]     br_bits;
  logic [7:0]     fork_tgt;
  logic           fork_on;
  logic [7:0]     addr_nxt;
  mseq_pkg::sub_t sub;

  assign sub = sub_rom(class_idx(ir_r));
  assign trap_take = cyc_en && rom.branch_enable_field == mseq_pkg::BR_TRAP && O_TRAP_ACTIVE;

  always_comb begin
    br_bits = 2'b00;
    case (rom.branch_enable_field)
      mseq_pkg::BR_DP0:  br_bits = {1'b0, I_COND[0]};
      mseq_pkg::BR_DP2:  br_bits = I_COND;
      mseq_pkg::BR_ZERO: br_bits = {1'b0, I_CC[2]};
      mseq_pkg::BR_NC:   br_bits = {I_CC[3], I_CC[0]};
      mseq_pkg::BR_TRAP: br_bits = {1'b0, O_TRAP_ACTIVE};
      mseq_pkg::BR_CONS: br_bits = {1'b0, I_CONSOLE};
      default:           br_bits = 2'b00;
    endcase
  end

  always_comb begin
    fork_on  = 1'b1;
    fork_tgt = 8'h00;
    case (rom.fork_enable_field)
      3'b001:  fork_tgt = {4'h0, fetch_fork_instruction_copy[15:12]};
      3'b010:  fork_tgt = {4'h0, sub.cls, ir_r[5:4]};
      3'b100:  fork_tgt = {4'h0, sub.cls, ir_r[11:10]};
      default: fork_on = 1'b0;
    endcase
  end

  always_comb begin
    addr_nxt = rom.next_addr | {6'h00, br_bits};
    if (fork_on) begin
      addr_nxt = (addr_nxt & ~mseq_pkg::FORK_MASK) | (fork_tgt & mseq_pkg::FORK_MASK);
    end
  end

  // Three identical address copies; copy 2 exported
  always_ff @(posedge I_CORE_CLK) begin
    for (int i = 0; i < mseq_pkg::CAR_COPIES; i++) begin
      if (!I_RST_N) begin
        car_r[i] <= mseq_pkg::START_ADDR;
      end else if (cyc_en) begin
        car_r[i] <= addr_nxt;
      end
    end
  end

  assign O_CTRL_ADDR = car_r[2];

  ////////////////////////////////////////////////////////////////////////
  // Control word latch and special control

  logic [2:0] sel_nxt;
  logic       we_nxt;
  logic [7:0] flg_nxt;

  always_comb begin
    case (rom.dp.reg_src)
      mseq_pkg::RS_IR_SRC: sel_nxt = ir_r[8:6];
      mseq_pkg::RS_IR_DST: sel_nxt = ir_r[2:0];
      mseq_pkg::RS_SWITCH: sel_nxt = I_SWITCH;
      default:             sel_nxt = rom.dp.reg_field;
    endcase
    we_nxt = rom.dp.register_write_field == mseq_pkg::RW_WRITE ||
             (rom.dp.register_write_field == mseq_pkg::RW_COND && sel_nxt != mseq_pkg::REG_PC);
  end

  always_comb begin
    case (rom.dp.flag_update_field)
      mseq_pkg::FL_HOLD:  flg_nxt = {4{mseq_pkg::FA_HOLD}};
      mseq_pkg::FL_LOAD:  flg_nxt = {4{mseq_pkg::FA_LOAD}};
      mseq_pkg::FL_CLEAR: flg_nxt = {4{mseq_pkg::FA_CLR}};
      default:            flg_nxt = sub.flags;
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      O_DP_CTRL  <= mseq_pkg::NOP_DP;
      O_ALU_SEL  <= 6'h00;
      O_FLAG_CTL <= 8'h00;
      O_REG_SEL  <= 3'h0;
      O_REG_WE   <= 1'b0;
    end else if (cyc_en) begin
      O_DP_CTRL  <= rom.dp;
      O_ALU_SEL  <= (rom.dp.alu_fld == mseq_pkg::ALU_SUBROM) ? sub.alu : alu_expand(rom.dp.alu_fld);
      O_FLAG_CTL <= flg_nxt;
      O_REG_SEL  <= sel_nxt;
      O_REG_WE   <= we_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);

  sequence s_plain_step;
    cyc_en && rom.fork_enable_field == 3'b000;
  endsequence

  sequence s_bus_wait;
    !O_CPU_MASTER && rom.dp.ubus_xfer;
  endsequence

  latch_load_a: assert property (cyc_en |=> O_DP_CTRL == $past(rom.dp) && O_CYCLE)
    else $error("latch did not take addressed word");
  addr_field_a: assert property (s_plain_step |=> (O_CTRL_ADDR & $past(rom.next_addr)) == $past(rom.next_addr))
    else $error("address field bits lost");
  addr_hold_a: assert property (!cyc_en |=> $stable(O_CTRL_ADDR) && $stable(O_DP_CTRL))
    else $error("state moved without cycle enable");
  car_copies_a: assert property (car_r[0] == car_r[1] && car_r[1] == car_r[2])
    else $error("address copies differ");
  fork_multi_a: assert property (cyc_en && $countones(rom.fork_enable_field) > 1
                                 |=> O_CTRL_ADDR == ($past(rom.next_addr) | {6'h00, $past(br_bits)}))
    else $error("multiple forks honoured");
  trap_entry_a: assert property (cyc_en && rom.branch_enable_field == mseq_pkg::BR_TRAP && O_TRAP_ACTIVE
                                 |=> O_CTRL_ADDR[0])
    else $error("trap branch not taken");
  bus_wait_a: assert property (s_bus_wait |-> !cyc_en)
    else $error("system bus transfer without mastership");
  free_master_a: assert property (!breq_s && !I_PROGRAMMED_INTERRUPT_REQUEST_REQ |=> O_CPU_MASTER)
    else $error("processor not master while bus idle");
  programmed_interrupt_request_only_a: assert property (O_PROGRAMMED_INTERRUPT_REQUEST_GRANT |-> !O_CPU_MASTER && !O_EXT_GRANT)
    else $error("interrupt grant overlaps other master");
  pc_write_a: assert property (cyc_en && rom.dp.register_write_field == mseq_pkg::RW_COND
                               && sel_nxt == mseq_pkg::REG_PC |=> !O_REG_WE)
    else $error("conditional write to register 7");
  alu_sub_a: assert property (cyc_en && rom.dp.alu_fld == mseq_pkg::ALU_SUBROM |=> O_ALU_SEL == $past(sub.alu))
    else $error("lookup ALU selects not used");
  reset_start_a: assert property ($rose(I_RST_N) |-> O_CTRL_ADDR == mseq_pkg::START_ADDR
                                  && O_DP_CTRL == mseq_pkg::NOP_DP)
    else $error("reset state wrong");

endmodule

// file: verilog/mseq_pkg.sv
package mseq_pkg;

  localparam int CS_WORDS    = 256;
  localparam int CA_W        = 8;
  localparam int CAR_COPIES  = 3;
  localparam int CYC_DIV_DEF = 4;
  localparam int N_ASYNC     = 3;

  localparam logic [7:0] START_ADDR = 8'h00;
  localparam logic [7:0] FORK_MASK  = 8'h0F;
  localparam logic [2:0] REG_PC     = 3'h7;

  // APB byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_CS_ADDR = 8'h08;
  localparam logic [7:0] OFF_CS_DATA = 8'h0C;

  localparam int CTRL_RUN   = 0;
  localparam int ST_VEC_LSB = 8;
  localparam int ST_MASTER  = 16;
  localparam int ST_TRAP    = 17;
  localparam int ST_STALL   = 18;

  // Trap vectors, highest priority first
  localparam logic [7:0] VEC_PWR   = 8'h04;
  localparam logic [7:0] VEC_ODD   = 8'h08;
  localparam logic [7:0] VEC_STACK = 8'h0C;
  localparam logic [7:0] VEC_RSVD  = 8'h10;

  localparam logic [1:0] FA_HOLD = 2'h0;
  localparam logic [1:0] FA_LOAD = 2'h1;
  localparam logic [1:0] FA_CLR  = 2'h2;
  localparam logic [1:0] FA_SET  = 2'h3;

  localparam logic [2:0] ALU_SUBROM = 3'h7;

  typedef enum logic [2:0] {
    BR_NONE = 3'b000, BR_DP0  = 3'b001, BR_DP2 = 3'b010, BR_ZERO = 3'b011,
    BR_NC   = 3'b100, BR_TRAP = 3'b101, BR_CONS = 3'b110, BR_RSV = 3'b111
  } br_t;

  typedef enum logic [1:0] {
    FL_HOLD = 2'b00, FL_LOAD = 2'b01, FL_CLEAR = 2'b10, FL_INSTR = 2'b11
  } flag_t;

  typedef enum logic [1:0] {
    RS_IR_SRC = 2'b00, RS_IR_DST = 2'b01, RS_SWITCH = 2'b10, RS_FIELD = 2'b11
  } rsrc_t;

  typedef enum logic [1:0] {
    RW_NONE = 2'b00, RW_WRITE = 2'b01, RW_COND = 2'b10, RW_RSV = 2'b11
  } rw_t;

  // Latched part of the control word
  typedef struct packed {
    logic [3:0] dp_misc;
    logic       ubus_xfer;
    logic       fbus_xfer;
    rw_t        register_write_field;
    logic [2:0] reg_field;
    rsrc_t      reg_src;
    flag_t      flag_update_field;
    logic [2:0] alu_fld;
  } dp_t;

  typedef struct packed {
    dp_t        dp;
    logic [2:0] fork_enable_field;
    br_t        branch_enable_field;
    logic [7:0] next_addr;
  } cw_t;

  typedef struct packed {
    logic [1:0] cls;
    logic [7:0] flags;
    logic [5:0] alu;
  } sub_t;

  localparam dp_t NOP_DP = '0;

endpackage
